// ---- ee_loader_pkg.sv ----
// Summary of operation
// R01: Size of the attached serial memory, 64 or 256 words, is found automatically.
// R02: Every read and write starts with a start bit and two-bit command.
// R03: Address field is six bits for 64 words, eight bits for 256 words.
// R04: Memory answers a zero after the last address bit; used to detect width.
// R05: Autonomous heartbeat windows; host memory and flash accesses are retried meanwhile.
// R06: After reset the words 0h, 1h, 2h, Ah and Dh are loaded automatically.
// R07: Modem flag, word Ah bit 0, adds words Bh, Ch, FBh, FCh, FDh, FEh.
// R08: Card-bus systems must fit a 256-word memory holding card data.
// R09: Heartbeat systems must fit a 256-word memory holding the packet.
// R10: Station address from words 00h-02h, low byte is the odd-numbered byte.
// R11: Checksum word sits at 3Fh or FFh by size, high byte in bits 15-8.
// R12: Word 0Dh: high byte configuration pointer, low byte bus address and card pointer.
// R13: Device identification comes from word 23h, high byte in bits 15-8.
// R14: Words 40h-F7h belong to the alert agent, F8h-FEh to software.
// R15: A flag in word Ah disables the expansion ROM window decode.
// R16: After the dummy zero sixteen data bits follow, most significant first.
`default_nettype none
package ee_loader_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int SK_HZ = 1250000;
  // Half period of the serial clock, rounded so the rate never exceeds SK_HZ
  localparam int SK_HALF_CYC = (CLK_HZ + 2 * SK_HZ - 1) / (2 * SK_HZ);
  localparam logic [3:0] SK_HALF_LAST = 4'(SK_HALF_CYC - 1);
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [4:0] CMD_BITS = 5'h03;
  localparam logic [4:0] ADDR_BITS_SMALL = 5'h06;
  localparam logic [4:0] ADDR_BITS_LARGE = 5'h08;
  localparam logic [4:0] DATA_BITS = 5'h10;
  localparam logic [7:0] W_ADDR0 = 8'h00;
  localparam logic [7:0] W_ADDR2 = 8'h02;
  localparam logic [7:0] W_SIG = 8'h0a;
  localparam logic [7:0] W_PTRS = 8'h0d;
  localparam logic [7:0] W_DEVID = 8'h23;
  localparam logic [7:0] W_CSUM_SMALL = 8'h3f;
  localparam logic [7:0] W_CSUM_LARGE = 8'hff;
  localparam logic [7:0] ASF_FIRST = 8'h40;
  localparam logic [7:0] ASF_LAST = 8'hf7;
  localparam logic [7:0] SW_FIRST = 8'hf8;
  localparam logic [7:0] SW_LAST = 8'hfe;
  localparam int MODEM_BIT = 0;
  localparam int ROM_DIS_BIT = 1;
  localparam logic [3:0] LOAD_BASE_LAST = 4'h3;
  localparam logic [3:0] LOAD_FULL_LAST = 4'h9;

  typedef enum logic [2:0] {
    ST_PROBE = 3'b000,
    ST_PROBE_WAIT = 3'b001,
    ST_LOAD = 3'b010,
    ST_LOAD_WAIT = 3'b011,
    ST_IDLE = 3'b100,
    ST_XFER_WAIT = 3'b101
  } ctl_state_t;
endpackage
`default_nettype wire

// ---- ee_serial_engine.sv ----
`default_nettype none
module ee_serial_engine (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic probe,
  input wire logic [1:0] op,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wide,
  input wire logic ee_do,
  output logic ee_cs,
  output logic ee_sk,
  output logic ee_di,
  output logic busy,
  output logic done,
  output logic found_wide,
  output logic [15:0] rdata
);
  import ee_loader_pkg::*;

  logic [3:0] div_r;
  logic [4:0] cnt_r;
  logic [4:0] alen_r;
  logic [26:0] tx_r;
  logic probe_r;
  logic read_r;
  logic do_meta_r;
  logic do_s_r;
  logic tick;
  logic [4:0] cnt_nxt;

  assign tick = busy && (div_r == SK_HALF_LAST);
  assign cnt_nxt = cnt_r + 5'h01;
  assign ee_di = tx_r[26];

  always_ff @(posedge clk) begin
    do_meta_r <= ee_do;
    do_s_r <= do_meta_r;
  end

  always_ff @(posedge clk) begin
    if (reset || !busy || tick) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (reset) begin
      busy <= 1'b0;
      ee_cs <= 1'b0;
      ee_sk <= 1'b0;
      cnt_r <= 5'h00;
      alen_r <= ADDR_BITS_LARGE;
      tx_r <= '0;
      probe_r <= 1'b0;
      read_r <= 1'b0;
      found_wide <= 1'b1;
      rdata <= 16'h0000;
    end else if (start && !busy) begin
      busy <= 1'b1;
      ee_cs <= 1'b1;
      ee_sk <= 1'b0;
      cnt_r <= 5'h00;
      probe_r <= probe;
      read_r <= (op == OP_READ);
      if (probe || wide) begin // [R03]
        alen_r <= ADDR_BITS_LARGE;
        tx_r <= {1'b1, op, addr, wdata}; // [R02]
      end else begin
        alen_r <= ADDR_BITS_SMALL;
        tx_r <= {1'b1, op, addr[5:0], wdata, 2'b00}; // [R02] [R03]
      end
    end else if (tick) begin
      ee_sk <= !ee_sk;
      if (ee_sk) begin
        // Falling edge: take the answer of the bit just clocked, present the next
        cnt_r <= cnt_nxt;
        tx_r <= {tx_r[25:0], 1'b0};
        if (probe_r && cnt_nxt == CMD_BITS + ADDR_BITS_SMALL && !do_s_r) begin // [R01] [R04]
          alen_r <= ADDR_BITS_SMALL;
          found_wide <= 1'b0;
        end
        if (probe_r && cnt_nxt == CMD_BITS + ADDR_BITS_LARGE && alen_r == ADDR_BITS_LARGE) begin
          found_wide <= 1'b1; // [R01] [R04]
        end
        if (read_r && cnt_r >= CMD_BITS + alen_r) begin
          rdata <= {rdata[14:0], do_s_r}; // [R16]
        end
        if (cnt_nxt == CMD_BITS + alen_r + DATA_BITS) begin
          busy <= 1'b0;
          ee_cs <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule // ee_serial_engine
`default_nettype wire

// ---- ee_config_loader.sv ----
`default_nettype none
module ee_config_loader (
  input wire logic clk,
  input wire logic reset,
  input wire logic ee_do,
  output logic ee_cs,
  output logic ee_sk,
  output logic ee_di,
  input wire logic host_req,
  input wire logic host_is_flash,
  input wire logic host_write,
  input wire logic [7:0] host_addr,
  input wire logic [15:0] host_wdata,
  output logic host_retry,
  output logic host_done,
  output logic flash_go,
  output logic [15:0] rd_word,
  output logic addr_in_asf,
  output logic addr_in_sw,
  input wire logic hb_req,
  input wire logic [7:0] hb_addr,
  output logic hb_window,
  output logic hb_done,
  output logic load_done,
  output logic size_wide,
  output logic [47:0] station_address,
  output logic [15:0] image_signature_word,
  output logic modem_present,
  output logic exp_rom_disable,
  output logic [7:0] config_hb_pointer,
  output logic [7:0] smb_cis_pointer,
  output logic [15:0] subsys_ident_word,
  output logic [15:0] subsys_vendor_word,
  output logic [63:0] sw_words,
  output logic [15:0] device_ident,
  output logic [15:0] image_checksum,
  output logic [7:0] checksum_addr
);
  import ee_loader_pkg::*;

  ctl_state_t state_r;
  logic [3:0] idx_r;
  logic eng_start;
  logic eng_probe;
  logic [1:0] eng_op;
  logic [7:0] eng_addr;
  logic eng_busy;
  logic eng_done;
  logic eng_wide;
  logic [15:0] eng_rdata;
  logic [7:0] cur_addr_r;
  logic cur_read_r;
  logic cur_host_r;
  logic host_take;

  function automatic logic [7:0] load_word(input logic [3:0] i);
    case (i)
      4'h0: load_word = 8'h01;
      4'h1: load_word = W_ADDR2;
      4'h2: load_word = W_SIG;
      4'h3: load_word = W_PTRS;
      4'h4: load_word = 8'h0b;
      4'h5: load_word = 8'h0c;
      4'h6: load_word = 8'hfb;
      4'h7: load_word = 8'hfc;
      4'h8: load_word = 8'hfd;
      default: load_word = 8'hfe;
    endcase
  endfunction

  ee_serial_engine u_engine (
    .clk(clk),
    .reset(reset),
    .start(eng_start),
    .probe(eng_probe),
    .op(eng_op),
    .addr(eng_addr),
    .wdata(host_wdata),
    .wide(size_wide),
    .ee_do(ee_do),
    .ee_cs(ee_cs),
    .ee_sk(ee_sk),
    .ee_di(ee_di),
    .busy(eng_busy),
    .done(eng_done),
    .found_wide(eng_wide),
    .rdata(eng_rdata)
  );

  // Host gets through only when idle and no heartbeat window is open
  assign host_retry = host_req && (state_r != ST_IDLE || hb_window || hb_req); // [R05]
  assign host_take = host_req && !host_retry;
  assign flash_go = host_take && host_is_flash;
  assign eng_probe = (state_r == ST_PROBE);
  assign eng_start = (state_r == ST_PROBE) || (state_r == ST_LOAD) ||
                     (state_r == ST_IDLE && ((hb_req && !hb_window) || (host_take && !host_is_flash)));
  assign eng_op = (state_r == ST_IDLE && !hb_req && host_write) ? OP_WRITE : OP_READ;
  assign eng_addr = (state_r == ST_PROBE) ? W_ADDR0 :
                    (state_r == ST_LOAD) ? load_word(idx_r) :
                    (hb_req ? hb_addr : host_addr);
  assign checksum_addr = size_wide ? W_CSUM_LARGE : W_CSUM_SMALL; // [R11]

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_PROBE;
      idx_r <= 4'h0;
      load_done <= 1'b0;
      hb_window <= 1'b0;
      cur_addr_r <= 8'h00;
      cur_read_r <= 1'b1;
      cur_host_r <= 1'b0;
    end else begin
      case (state_r)
        ST_PROBE: begin
          cur_addr_r <= W_ADDR0;
          cur_read_r <= 1'b1;
          state_r <= ST_PROBE_WAIT; // [R01]
        end
        ST_PROBE_WAIT: if (eng_done) begin
          state_r <= ST_LOAD; // [R06]
        end
        ST_LOAD: begin
          cur_addr_r <= load_word(idx_r);
          state_r <= ST_LOAD_WAIT;
        end
        ST_LOAD_WAIT: if (eng_done) begin
          idx_r <= idx_r + 4'h1;
          if (idx_r == LOAD_FULL_LAST ||
              (idx_r == LOAD_BASE_LAST && !image_signature_word[MODEM_BIT])) begin // [R07]
            state_r <= ST_IDLE;
            load_done <= 1'b1;
          end else begin
            state_r <= ST_LOAD; // [R06]
          end
        end
        ST_IDLE: begin
          if (hb_req && !hb_window) begin
            hb_window <= 1'b1; // [R05]
            cur_addr_r <= hb_addr;
            cur_read_r <= 1'b1;
            cur_host_r <= 1'b0;
            state_r <= ST_XFER_WAIT;
          end else if (hb_window && !hb_req) begin
            hb_window <= 1'b0;
          end else if (host_take && !host_is_flash) begin
            cur_addr_r <= host_addr;
            cur_read_r <= !host_write;
            cur_host_r <= 1'b1;
            state_r <= ST_XFER_WAIT;
          end
        end
        ST_XFER_WAIT: if (eng_done) begin
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_PROBE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      host_done <= 1'b0;
      hb_done <= 1'b0;
      rd_word <= 16'h0000;
      addr_in_asf <= 1'b0;
      addr_in_sw <= 1'b0;
    end else begin
      host_done <= eng_done && cur_host_r && state_r == ST_XFER_WAIT;
      hb_done <= eng_done && !cur_host_r && state_r == ST_XFER_WAIT;
      if (eng_done && cur_read_r) begin
        rd_word <= eng_rdata; // [R16]
      end
      if (host_take) begin
        addr_in_asf <= host_addr >= ASF_FIRST && host_addr <= ASF_LAST && size_wide; // [R14]
        addr_in_sw <= host_addr >= SW_FIRST && host_addr <= SW_LAST && size_wide; // [R14]
      end
    end
  end

  // Captures every completed read of a known word, whoever asked for it
  always_ff @(posedge clk) begin
    if (reset) begin
      size_wide <= 1'b1;
      station_address <= 48'h0;
      image_signature_word <= 16'h0000;
      config_hb_pointer <= 8'h00;
      smb_cis_pointer <= 8'h00;
      subsys_ident_word <= 16'h0000;
      subsys_vendor_word <= 16'h0000;
      sw_words <= 64'h0;
      device_ident <= 16'h0000;
      image_checksum <= 16'h0000;
    end else if (eng_done && cur_read_r) begin
      if (state_r == ST_PROBE_WAIT) begin
        size_wide <= eng_wide; // [R01] [R03]
      end
      case (cur_addr_r)
        W_ADDR0: station_address[15:0] <= eng_rdata; // [R10]
        8'h01: station_address[31:16] <= eng_rdata; // [R10]
        W_ADDR2: station_address[47:32] <= eng_rdata; // [R10]
        W_SIG: image_signature_word <= eng_rdata;
        8'h0b: subsys_ident_word <= eng_rdata;
        8'h0c: subsys_vendor_word <= eng_rdata;
        W_PTRS: begin
          config_hb_pointer <= eng_rdata[15:8]; // [R12]
          smb_cis_pointer <= eng_rdata[7:0]; // [R12]
        end
        W_DEVID: device_ident <= {eng_rdata[15:8], eng_rdata[7:0]}; // [R13]
        8'hfb: sw_words[15:0] <= eng_rdata;
        8'hfc: sw_words[31:16] <= eng_rdata;
        8'hfd: sw_words[47:32] <= eng_rdata;
        8'hfe: sw_words[63:48] <= eng_rdata;
        default: begin
        end
      endcase
      if (cur_addr_r == checksum_addr) begin
        image_checksum <= eng_rdata; // [R11]
      end
    end
  end

  assign modem_present = image_signature_word[MODEM_BIT]; // [R07]
  assign exp_rom_disable = image_signature_word[ROM_DIS_BIT]; // [R15]
endmodule // ee_config_loader
`default_nettype wire

// ---- ee_checks_assertions.sv ----
`default_nettype none
module ee_checks (
  input wire logic clk,
  input wire logic reset,
  input wire logic ee_cs,
  input wire logic ee_sk,
  input wire logic ee_di,
  input wire logic host_req,
  input wire logic host_is_flash,
  input wire logic host_retry,
  input wire logic flash_go,
  input wire logic hb_req,
  input wire logic hb_window,
  input wire logic hb_done,
  input wire logic load_done,
  input wire logic size_wide,
  input wire logic [7:0] checksum_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence sk_low8;
    !ee_sk [*8] ##1 ee_sk;
  endsequence
  sequence sk_high8;
    ee_sk [*8] ##1 !ee_sk;
  endsequence
  frame_start_a: assert property ($rose(ee_cs) |-> ee_di ##0 sk_low8) else $error("bad frame start");
  sk_high_a: assert property ($rose(ee_sk) |-> sk_high8) else $error("bad sk high time");
  sk_idle_a: assert property (!ee_cs |-> !ee_sk) else $error("sk without cs");
  di_hold_a: assert property (ee_sk |-> $stable(ee_di)) else $error("di moved in sk high");
  load_retry_a: assert property (host_req && !load_done |-> host_retry) else $error("no retry in load");
  window_retry_a: assert property (host_req && (hb_req || hb_window) |-> host_retry)
    else $error("no retry in window");
  flash_go_a: assert property (flash_go |-> host_is_flash && load_done && !hb_req && !hb_window)
    else $error("flash taken wrongly");
  hb_done_a: assert property (hb_done |-> hb_window ##1 !hb_done) else $error("bad hb done");
  load_hold_a: assert property (load_done |=> load_done) else $error("load done fell");
  csum_addr_a: assert property (checksum_addr == (size_wide ? 8'hff : 8'h3f))
    else $error("bad checksum address");
endmodule // ee_checks
bind ee_config_loader ee_checks ee_checks_i (.clk, .reset, .ee_cs, .ee_sk, .ee_di, .host_req, .host_is_flash,
  .host_retry, .flash_go, .hb_req, .hb_window, .hb_done, .load_done, .size_wide, .checksum_addr);
`default_nettype wire

// ---- ee_model.sv ----
`default_nettype none
module ee_model (
  input wire logic ee_cs,
  input wire logic ee_sk,
  input wire logic ee_di,
  input wire logic wide,
  output logic ee_do
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [256];
  logic [15:0] sh;
  logic [7:0] adr;
  logic [1:0] op;
  logic do_r;
  int n = 0;
  int al;
  assign al = wide ? 8 : 6;
  // Deselected line sits at its pull-up level
  assign ee_do = ee_cs ? do_r : 1'b1;
  always @(posedge ee_sk or negedge ee_cs) begin
    if (!ee_cs) begin
      n = 0;
      do_r = 1'b1;
    end else begin
      n = n + 1;
      if (n <= 3)
        op = {op[0], ee_di};
      else if (n <= 3 + al)
        adr = {adr[6:0], ee_di};
      else if (op == 2'h1)
        sh = {sh[14:0], ee_di};
      if (n == 3 + al && op == 2'h2) begin
        do_r = 1'b0;
        sh = mem[wide ? adr : {2'b00, adr[5:0]}];
      end else if (n > 3 + al && n <= 19 + al && op == 2'h2)
        do_r = sh[19 + al - n];
      if (n == 19 + al && op == 2'h1)
        mem[wide ? adr : {2'b00, adr[5:0]}] = sh;
    end
  end
endmodule // ee_model
`default_nettype wire

// ---- testbench.sv ----
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, ee_do, ee_cs, ee_sk, ee_di, wide, host_req, host_is_flash, host_write, host_retry;
  logic host_done, flash_go, addr_in_asf, addr_in_sw, hb_req, hb_window, hb_done, load_done, size_wide;
  logic modem_present, exp_rom_disable;
  logic [7:0] host_addr, hb_addr, config_hb_pointer, smb_cis_pointer, checksum_addr;
  logic [15:0] host_wdata, rd_word, image_signature_word, subsys_ident_word, subsys_vendor_word;
  logic [15:0] device_ident, image_checksum, d;
  logic [47:0] station_address;
  logic [63:0] sw_words;
  logic [15:0] ref_mem [256];
  int n_errors = 0;
  int cmp_count = 0;
  int seed = 32'hb9ceb7d6;
  ee_config_loader ee_config_loader_i (.clk, .reset, .ee_do, .ee_cs, .ee_sk, .ee_di, .host_req, .host_is_flash,
    .host_write, .host_addr, .host_wdata, .host_retry, .host_done, .flash_go, .rd_word, .addr_in_asf,
    .addr_in_sw, .hb_req, .hb_addr, .hb_window, .hb_done, .load_done, .size_wide, .station_address,
    .image_signature_word, .modem_present, .exp_rom_disable, .config_hb_pointer, .smb_cis_pointer,
    .subsys_ident_word, .subsys_vendor_word, .sw_words, .device_ident, .image_checksum, .checksum_addr);
  ee_model ee_model_i (.ee_cs, .ee_sk, .ee_di, .wide, .ee_do);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task finish_test;
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task cmp16(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cmp1(input string nm, input logic e, input logic g);
    cmp16(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic wt(ref logic s, input logic v);
    for (int i = 0; i < 20000 && s !== v; i++)
      @(negedge clk);
    if (s !== v) begin
      n_errors++;
      $display("CHECK FAILED wait expected %b seen %b", v, s);
      finish_test();
    end
  endtask
  task host(input logic w, input logic f, input logic [7:0] a, input logic [15:0] dv);
    logic [7:0] ix;
    ix = wide ? a : {2'b00, a[5:0]};
    @(posedge clk);
    host_req <= 1'b1;
    host_write <= w;
    host_is_flash <= f;
    host_addr <= a;
    host_wdata <= dv;
    @(negedge clk);
    wt(host_retry, 1'b0);
    cmp1("flash_go", f, flash_go);
    @(posedge clk);
    host_req <= 1'b0;
    if (!f) begin
      @(negedge clk);
      wt(host_done, 1'b1);
      cmp1("addr_in_asf", wide && a >= 8'h40 && a <= 8'hf7, addr_in_asf);
      cmp1("addr_in_sw", wide && a >= 8'hf8 && a <= 8'hfe, addr_in_sw);
      if (w)
        ref_mem[ix] = dv;
      else
        cmp16("rd_word", ref_mem[ix], rd_word);
    end
  endtask
  task hb(input logic [7:0] a);
    @(posedge clk);
    hb_req <= 1'b1;
    hb_addr <= a;
    host_req <= 1'b1;
    host_is_flash <= 1'b1;
    @(negedge clk);
    wt(hb_window, 1'b1);
    cmp1("host_retry", 1'b1, host_retry);
    wt(hb_done, 1'b1);
    cmp16("hb_word", ref_mem[a], rd_word);
    @(posedge clk);
    hb_req <= 1'b0;
    host_req <= 1'b0;
    repeat (2) @(negedge clk);
    cmp1("hb_window", 1'b0, hb_window);
  endtask
  task do_reset(input logic w);
    @(posedge clk);
    reset <= 1'b1;
    wide <= w;
    for (int i = 0; i < 256; i++)
      ref_mem[i] = 16'($random(seed));
    // Modem words only in the large pass
    ref_mem[8'h0a][0] = w;
    ee_model_i.mem = ref_mem;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    host_req <= 1'b1;
    host_is_flash <= 1'b0;
    @(negedge clk);
    cmp1("host_retry", 1'b1, host_retry);
    @(posedge clk);
    host_req <= 1'b0;
    wt(load_done, 1'b1);
    cmp1("size_wide", w, size_wide);
    cmp16("checksum_addr", {8'h00, w ? 8'hff : 8'h3f}, {8'h00, checksum_addr});
    for (int i = 0; i < 3; i++)
      cmp16("station_address", ref_mem[i], station_address[16*i+:16]);
    cmp16("signature", ref_mem[8'h0a], image_signature_word);
    cmp16("pointers", ref_mem[8'h0d], {config_hb_pointer, smb_cis_pointer});
    cmp1("modem_present", w, modem_present);
    cmp1("exp_rom_disable", ref_mem[8'h0a][1], exp_rom_disable);
    cmp16("subsys_ident", w ? ref_mem[8'h0b] : 16'h0000, subsys_ident_word);
    cmp16("subsys_vendor", w ? ref_mem[8'h0c] : 16'h0000, subsys_vendor_word);
    for (int i = 0; i < 4; i++)
      cmp16("sw_words", w ? ref_mem[8'hfb + i] : 16'h0000, sw_words[16*i+:16]);
  endtask
  initial begin
    reset = 1'b1;
    wide = 1'b0;
    host_req = 1'b0;
    host_is_flash = 1'b0;
    host_write = 1'b0;
    host_addr = 8'h00;
    host_wdata = 16'h0000;
    hb_req = 1'b0;
    hb_addr = 8'h00;
    do_reset(1'b0);
    host(1'b0, 1'b0, 8'h23, 16'h0000);
    cmp16("device_ident", ref_mem[8'h23], device_ident);
    host(1'b0, 1'b0, 8'h3f, 16'h0000);
    cmp16("image_checksum", ref_mem[8'h3f], image_checksum);
    d = 16'($random(seed));
    host(1'b1, 1'b0, 8'h45, d);
    host(1'b0, 1'b0, 8'h45, 16'h0000);
    host(1'b0, 1'b1, 8'h10, 16'h0000);
    do_reset(1'b1);
    d = 16'($random(seed));
    host(1'b1, 1'b0, 8'hfa, d);
    host(1'b0, 1'b0, 8'hfa, 16'h0000);
    host(1'b0, 1'b0, 8'h45, 16'h0000);
    hb(8'hff);
    cmp16("image_checksum", ref_mem[8'hff], image_checksum);
    hb(8'h23);
    cmp16("device_ident", ref_mem[8'h23], device_ident);
    finish_test();
  end
endmodule // testbench
`default_nettype wire
